// File: hdl/swq_defines.svh
// Constants for the sweep run sequencer: timing counts, field codes, reset values
`ifndef SWQ_DEFINES_SVH
`define SWQ_DEFINES_SVH
// Summary of operation
// - Gated mode outputs waveform only while sweeping, held or forced
// - Phase sweep gated: start/stop phase bound oscillation
// - Idle level from percentage or phase setting
// - Gated stop only at cycle/half-cycle boundary
// - Accept four trigger sources, light received lamp
// - Internal period programmable; external polarity selectable
// - Manual, remote, start command trigger whatever the source
// - Continuous mode starts sweeping without trigger
// - Invalid setup blocks start and triggers, flags
// - Single modes start one sweep per trigger
// - Stop command halts, outputs start value
// - After stop, new trigger resweeps from beginning
// - Hold freezes sweep; resume continues there
// - Trigger during hold restarts from start
// - Force start value; gated keeps oscillating
// - Force stop value; gated keeps oscillating
// - Four sync choices; reference phase sync
// - Sweep sync falls high to low at start
// - Marker sync low until marker, then high
// - Marker low clamped, resolution one of 32768
// - X drive ramp linear in time, inverts
// - One-way single returns start; shuttle waits done
`define SWQ_CLK_PERIOD_NS   25
`define SWQ_POS_W           15
`define SWQ_POS_MAX         15'h7FFF
`define SWQ_MARK_MIN        15'h0010
`define SWQ_MARK_MAX        15'h7FEF
`define SWQ_TRIG_PERIOD_RST 32'h0000_9C40
`define SWQ_RATE_RST        16'h0001
`define SWQ_LAMP_TIME_NS    100000000
`define SWQ_LAMP_CYCLES     (`SWQ_LAMP_TIME_NS / `SWQ_CLK_PERIOD_NS)
`define SWQ_SYNC_REF        2'h0
`define SWQ_SYNC_SWEEP      2'h1
`define SWQ_SYNC_MARK       2'h2
`define SWQ_SYNC_XDRIVE     2'h3
`endif

// File: hdl/swq_pkg.sv
// Types shared by the sweep run sequencer
package swq_pkg;
    typedef enum logic [1:0] {SWQ_CONT, SWQ_SINGLE, SWQ_GATED} swq_style_t;
    typedef enum logic [1:0] {SWQ_POL_OFF, SWQ_POL_RISE, SWQ_POL_FALL} swq_pol_t;
    typedef enum logic [2:0] {
        SWQ_STOPPED, SWQ_RUN, SWQ_HELD, SWQ_DONE, SWQ_FORCE_START, SWQ_FORCE_STOP
    } swq_state_t;
endpackage

// File: hdl/swq_trig_timer.sv
// Internal periodic trigger oscillator for the sweep run sequencer
`timescale 1ns/1ps
`default_nettype none
module swq_trig_timer (
    input  wire logic        mclk,       // System clock
    input  wire logic        resetn,     // Synchronous reset, active low
    input  wire logic        enable,     // Run the oscillator
    input  wire logic [31:0] period,     // Trigger period in clock cycles
    output logic             tick        // One-cycle trigger pulse
);
    logic [31:0] cnt_ff;                 // Cycles since last tick
    logic [31:0] nxt_cnt;
    wire         wrap = (cnt_ff + 32'h1 >= period);

    // Restart the count whenever disabled so a fresh enable waits a period
    assign nxt_cnt = (!enable || wrap) ? 32'h0 : cnt_ff + 32'h1;

    // Counter and tick register
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cnt_ff <= 32'h0;
            tick   <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick   <= enable && wrap;
        end
    end
endmodule
`default_nettype wire

// File: hdl/swq_sequencer.sv
// Sweep run sequencer: trigger handling, run control, forced values and sync output
`timescale 1ns/1ps
`default_nettype none
`include "swq_defines.svh"
module swq_sequencer (
    input  wire logic               mclk,                // System clock, 40 MHz
    input  wire logic               resetn,              // Synchronous reset, active low
    input  wire swq_pkg::swq_style_t sweep_run_style,    // Continuous, single or gated
    input  wire logic               sweep_mode_on,       // Sweep oscillation mode selected
    input  wire logic               config_valid,        // Sweep settings are consistent
    input  wire logic               shuttle,             // Shuttle (triangle) sweep form
    input  wire logic               phase_sweep,         // Swept quantity is phase
    input  wire logic               stop_below_start,    // Stop value below start value
    input  wire logic [15:0]        sweep_rate,          // Position step per clock
    input  wire logic [14:0]        marker_pos,          // Marker point along the sweep
    input  wire logic               trig_src_ext,        // Trigger source: 1 external
    input  wire swq_pkg::swq_pol_t  trig_polarity,       // External trigger edge
    input  wire logic [31:0]        trig_period,         // Internal trigger period, cycles
    input  wire logic               ext_trig_pin,        // TTL trigger input pin
    input  wire logic               manual_trigger_key,  // Manual key pulse
    input  wire logic               remote_trigger,      // Remote command pulse
    input  wire logic               start_cmd,           // Start command pulse
    input  wire logic               stop_cmd,            // Stop command pulse
    input  wire logic               hold_cmd,            // Hold command pulse
    input  wire logic               resume_cmd,          // Resume command pulse
    input  wire logic               force_start_value,   // Force start value pulse
    input  wire logic               force_stop_value,    // Force stop value pulse
    input  wire logic               idle_output_level,   // Idle level option on
    input  wire logic [6:0]         idle_percent,        // Idle level, % of full scale
    input  wire logic [15:0]        phase_setting,       // General phase setting
    input  wire logic [15:0]        start_phase,         // Sweep start phase
    input  wire logic [15:0]        stop_phase,          // Sweep stop phase
    input  wire logic               stop_granularity,    // 1: half_period_granule
    input  wire logic               wave_cycle_mark,     // Waveform at whole-cycle point
    input  wire logic               wave_half_mark,      // Waveform at half-cycle point
    input  wire logic               wave_ref_phase,      // Waveform at reference phase
    input  wire logic [1:0]         sync_output_select,  // Sync terminal choice
    output logic                    osc_enable,          // Synthesizer oscillating
    output logic [14:0]             sweep_pos,           // Present sweep point
    output logic                    sel_start_value,     // Output start value
    output logic                    sel_stop_value,      // Output stop value
    output logic                    idle_use_percent,    // Idle level from percentage
    output logic [6:0]              idle_level_pct,      // Idle level percentage
    output logic [15:0]             osc_start_phase,     // Oscillation start phase
    output logic [15:0]             osc_stop_phase,      // Oscillation stop phase
    output logic                    trig_lamp,           // Trigger-received indicator
    output logic                    conflict,            // Invalid sweep settings flag
    output logic                    sync_out,            // Sync terminal logic level
    output logic [14:0]             xdrive_level         // X drive ramp code, 0..3 V
);
    import swq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    swq_state_t  state_ff, nxt_state;          // Run state
    logic [15:0] acc_ff, nxt_acc;              // Sweep position with carry bit
    logic        back_ff, nxt_back;            // On return leg of shuttle
    logic        gate_ff, nxt_gate;            // Gated oscillation running
    logic        sync_ff, nxt_sync;            // Sync terminal register
    logic        ext_s1_ff, ext_s2_ff;         // Pin synchroniser
    logic        ext_s3_ff;                    // Previous synchronised level
    logic [31:0] lamp_ff;                      // Lamp hold count
    logic        int_tick;                     // Internal oscillator pulse

    ////////////////////////////////////////////////////////////////////////////
    // Trigger sources
    swq_trig_timer u_timer (
        .mclk   (mclk),
        .resetn (resetn),
        .enable (!trig_src_ext && sweep_mode_on),
        .period (trig_period),
        .tick   (int_tick)
    );

    // Polarity off masks noise on the pin entirely
    wire ext_edge = (trig_polarity == SWQ_POL_RISE) ? (ext_s2_ff && !ext_s3_ff) :
                    (trig_polarity == SWQ_POL_FALL) ? (!ext_s2_ff && ext_s3_ff) : 1'b0;
    wire src_trig = trig_src_ext ? ext_edge : int_tick;
    // Manual, remote and start act whatever the source
    wire any_trig = src_trig || manual_trigger_key || remote_trigger || start_cmd;
    wire triggered = (sweep_run_style != SWQ_CONT) && sweep_mode_on
                     && config_valid && any_trig;
    wire gated   = (sweep_run_style == SWQ_GATED);

    ////////////////////////////////////////////////////////////////////////////
    // Sweep position arithmetic
    wire [15:0] acc_step = acc_ff + sweep_rate;
    wire        leg_end  = acc_step[15];                       // Leg passes full scale
    wire        at_mark_raw = acc_ff[14:0] >= marker_pos;
    // Marker low time clamped well inside the sweep; 15-bit grid gives 1/32768
    wire [14:0] mark_clamped = (marker_pos < `SWQ_MARK_MIN) ? `SWQ_MARK_MIN :
                               (marker_pos > `SWQ_MARK_MAX) ? `SWQ_MARK_MAX : marker_pos;
    wire        past_mark = acc_ff[14:0] >= mark_clamped;
    // Gate may only close on the selected waveform boundary
    wire        boundary = stop_granularity ? (wave_cycle_mark || wave_half_mark)
                                            : wave_cycle_mark;
    wire        running  = (state_ff == SWQ_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // Run state machine
    always_comb begin
        nxt_state = state_ff;
        nxt_acc   = acc_ff;
        nxt_back  = back_ff;
        unique case (state_ff)
            SWQ_STOPPED, SWQ_DONE: begin
                if (sweep_run_style == SWQ_CONT && sweep_mode_on && config_valid) begin
                    nxt_state = SWQ_RUN;
                    nxt_acc   = 16'h0;
                    nxt_back  = 1'b0;
                end else if (triggered) begin
                    nxt_state = SWQ_RUN;
                    nxt_acc   = 16'h0;
                    nxt_back  = 1'b0;
                end
            end
            SWQ_RUN: begin
                if (triggered) begin
                    nxt_acc  = 16'h0;
                    nxt_back = 1'b0;
                end else if (hold_cmd) begin
                    nxt_state = SWQ_HELD;
                end else if (leg_end) begin
                    if (shuttle && !back_ff) begin
                        nxt_back = 1'b1;
                        nxt_acc  = 16'h0;
                    end else if (sweep_run_style == SWQ_CONT) begin
                        nxt_back = 1'b0;
                        nxt_acc  = 16'h0;
                    end else if (shuttle) begin
                        nxt_state = SWQ_DONE;
                        nxt_acc   = {1'b0, `SWQ_POS_MAX};
                    end else begin
                        nxt_state = SWQ_STOPPED;
                        nxt_acc   = 16'h0;
                    end
                end else begin
                    nxt_acc = acc_step;
                end
            end
            SWQ_HELD: begin
                if (triggered) begin
                    nxt_state = SWQ_RUN;
                    nxt_acc   = 16'h0;
                    nxt_back  = 1'b0;
                end else if (resume_cmd) begin
                    nxt_state = SWQ_RUN;
                end
            end
            SWQ_FORCE_START, SWQ_FORCE_STOP: begin
                if (triggered) begin
                    nxt_state = SWQ_RUN;
                    nxt_acc   = 16'h0;
                    nxt_back  = 1'b0;
                end
            end
            // Unused state codes fall back to the safe stopped state
            default: nxt_state = SWQ_STOPPED;
        endcase
        // Commands outrank sweep progress; stop outranks everything
        if (force_start_value) begin
            nxt_state = SWQ_FORCE_START;
            nxt_acc   = 16'h0;
            nxt_back  = 1'b0;
        end
        if (force_stop_value) begin
            nxt_state = SWQ_FORCE_STOP;
            nxt_acc   = {1'b0, `SWQ_POS_MAX};
            nxt_back  = 1'b0;
        end
        if (stop_cmd || !sweep_mode_on || !config_valid) begin
            nxt_state = SWQ_STOPPED;
            nxt_acc   = 16'h0;
            nxt_back  = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gate: opens with a sweep, closes only on a waveform boundary
    wire want_gate = running || state_ff == SWQ_HELD ||
                     state_ff == SWQ_FORCE_START || state_ff == SWQ_FORCE_STOP;
    assign nxt_gate = want_gate ? 1'b1 : (gate_ff && !boundary);

    ////////////////////////////////////////////////////////////////////////////
    // Sync terminal source
    always_comb begin
        nxt_sync = sync_ff;
        unique case (sync_output_select)
            `SWQ_SYNC_REF:    nxt_sync = wave_ref_phase;
            // Drops at the start of each forward leg, high for the rest of the sweep
            `SWQ_SYNC_SWEEP:  nxt_sync = !(running && acc_ff == 16'h0 && !back_ff);
            // Low up to the marker, high on the return leg
            `SWQ_SYNC_MARK:   nxt_sync = back_ff ? 1'b1 :
                                         (running ? past_mark : 1'b1);
            `SWQ_SYNC_XDRIVE: nxt_sync = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_ff  <= SWQ_STOPPED;
            acc_ff    <= 16'h0;
            back_ff   <= 1'b0;
            gate_ff   <= 1'b0;
            sync_ff   <= 1'b1;
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_s3_ff <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            acc_ff    <= nxt_acc;
            back_ff   <= nxt_back;
            gate_ff   <= nxt_gate;
            sync_ff   <= nxt_sync;
            ext_s1_ff <= ext_trig_pin;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
        end
    end

    // Lamp stretch so a single-cycle trigger is visible to the operator
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            lamp_ff <= 32'h0;
        end else if (triggered) begin
            lamp_ff <= 32'(`SWQ_LAMP_CYCLES);
        end else if (lamp_ff != 32'h0) begin
            lamp_ff <= lamp_ff - 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    wire [14:0] pos_now  = back_ff ? (`SWQ_POS_MAX - acc_ff[14:0]) : acc_ff[14:0];
    // Ramp follows elapsed time, not the swept value; inverted for falling sweeps
    wire [14:0] time_pos = (running || state_ff == SWQ_HELD || state_ff == SWQ_DONE)
                           ? pos_now : 15'h0000;
    assign xdrive_level = stop_below_start ? (`SWQ_POS_MAX - time_pos) : time_pos;
    assign sweep_pos        = pos_now;
    assign sel_stop_value   = (state_ff == SWQ_FORCE_STOP) || (state_ff == SWQ_DONE);
    assign sel_start_value  = (state_ff == SWQ_STOPPED) || (state_ff == SWQ_FORCE_START);
    // Free-running modes oscillate whenever sweep mode is on; gated follows the gate
    assign osc_enable       = gated ? gate_ff : sweep_mode_on;
    assign idle_use_percent = idle_output_level;
    assign idle_level_pct   = idle_percent;
    assign osc_start_phase  = (gated && phase_sweep) ? start_phase : phase_setting;
    assign osc_stop_phase   = (gated && phase_sweep) ? stop_phase : phase_setting;
    assign trig_lamp        = (lamp_ff != 32'h0);
    assign conflict         = sweep_mode_on && !config_valid;
    assign sync_out         = (sync_output_select == `SWQ_SYNC_XDRIVE) ? 1'b0 : sync_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    a_stop_start_value: assert property (@(posedge mclk) disable iff (!resetn)
        stop_cmd |=> sel_start_value && !sel_stop_value)
        else $error("stop did not select start value");
    a_hold_freezes: assert property (@(posedge mclk) disable iff (!resetn)
        (state_ff == SWQ_HELD) && !triggered && !resume_cmd && !stop_cmd
        && !force_start_value && !force_stop_value && sweep_mode_on && config_valid
        |=> $stable(acc_ff))
        else $error("held sweep moved");
    a_trig_restarts: assert property (@(posedge mclk) disable iff (!resetn)
        triggered && !stop_cmd && !force_start_value && !force_stop_value
        |=> acc_ff == 16'h0 && state_ff == SWQ_RUN)
        else $error("trigger did not restart sweep");
    a_conflict_blocks: assert property (@(posedge mclk) disable iff (!resetn)
        conflict |=> state_ff == SWQ_STOPPED)
        else $error("sweep ran with conflict");
    a_cont_autostart: assert property (@(posedge mclk) disable iff (!resetn)
        state_ff == SWQ_STOPPED && sweep_run_style == SWQ_CONT && sweep_mode_on
        && config_valid && !stop_cmd && !force_start_value && !force_stop_value
        |=> state_ff == SWQ_RUN)
        else $error("continuous sweep did not start");
    a_lamp_lights: assert property (@(posedge mclk) disable iff (!resetn)
        triggered |=> trig_lamp [*2])
        else $error("trigger lamp not lit");
    a_gate_boundary: assert property (@(posedge mclk) disable iff (!resetn)
        gated && $fell(gate_ff) |-> $past(boundary))
        else $error("gate closed off boundary");
    a_force_stop_val: assert property (@(posedge mclk) disable iff (!resetn)
        force_stop_value && !stop_cmd && sweep_mode_on && config_valid
        |=> sel_stop_value && sweep_pos == `SWQ_POS_MAX)
        else $error("force stop value not applied");
    a_mark_clamp: assert property (@(posedge mclk) disable iff (!resetn)
        running && !back_ff && acc_ff[14:0] < `SWQ_MARK_MIN && at_mark_raw
        && sync_output_select == `SWQ_SYNC_MARK |=> !sync_ff)
        else $error("marker sync high before marker");
endmodule
`default_nettype wire

// File: testbench/swq_trig_model.sv
// External TTL trigger source standing at the far side of the trigger input pin
`timescale 1ns/1ps
`default_nettype none
module swq_trig_model (
    input  wire logic mclk,         // Bench clock
    input  wire logic resetn,       // Bench reset, active low
    input  wire logic fire,         // Request one trigger pulse
    output logic      ext_trig_pin, // TTL trigger line, idles low
    output logic      cycle_mark,   // Synthesizer at whole-cycle point
    output logic      half_mark     // Synthesizer at half-cycle point
);
    logic [1:0] cnt_ff;             // Remaining high cycles of the pulse
    logic [2:0] ph_ff;              // Synthesizer phase, eight clocks per cycle
    // Two-cycle high pulse gives a rising edge then a falling edge
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cnt_ff <= 2'h0;
            ph_ff  <= 3'h0;
        end else begin
            ph_ff <= ph_ff + 3'h1;
            if (fire) begin
                cnt_ff <= 2'h2;
            end else if (cnt_ff != 2'h0) begin
                cnt_ff <= cnt_ff - 2'h1;
            end
        end
    end
    // Line falls back to its pulled-down idle level after the pulse
    assign ext_trig_pin = (cnt_ff != 2'h0);
    // Waveform boundaries so the gate has somewhere to close
    assign cycle_mark   = (ph_ff == 3'h0);
    assign half_mark    = (ph_ff == 3'h4);
endmodule
`default_nettype wire

// File: testbench/sweep_run_sequencer_tb.sv
// Self-checking bench for the sweep run sequencer
`timescale 1ns/1ps
`default_nettype none
`include "swq_defines.svh"
module sweep_run_sequencer_tb;
    import swq_pkg::*;
    logic mclk = 0, resetn = 0, on = 1, valid = 1, shut = 0, phs = 0, sbs = 0, ext = 1;
    logic man = 0, rem = 0, sta = 0, stp = 0, hld = 0, res = 0, fst = 0, fsp = 0, fire = 0;
    logic idl = 1, gran = 0, pin, flag, cmk, hmk;
    logic [14:0] mk = 15'h4000;
    logic [31:0] tp = 32'h0000_0008;
    int n;
    logic [1:0] ssel = 2'h0;
    logic [14:0] p;
    swq_style_t sty = SWQ_SINGLE;
    swq_pol_t pol = SWQ_POL_OFF;
    logic osc, s0, s1, iup, lamp, cfl, so;
    logic [14:0] pos, xd;
    logic [6:0] ipl;
    logic [15:0] osp, opp;
    int error_cnt = 0, samples_checked = 0;
    // Row: kind[8:6] style[5:4] valid[3] polarity[2:1] expected run[0]
    logic [8:0] rows [8] = '{9'b001_01_1_00_1, 9'b010_10_1_00_1, 9'b011_01_1_00_1,
        9'b100_01_1_01_1, 9'b100_01_1_00_0, 9'b001_01_0_00_0, 9'b101_01_1_00_1,
        9'b100_10_1_10_1};
    swq_trig_model swq_trig_model_inst (.mclk(mclk), .resetn(resetn), .fire(fire),
        .ext_trig_pin(pin), .cycle_mark(cmk), .half_mark(hmk));
    swq_sequencer swq_sequencer_inst (.mclk(mclk), .resetn(resetn), .sweep_run_style(sty),
        .sweep_mode_on(on), .config_valid(valid), .shuttle(shut), .phase_sweep(phs),
        .stop_below_start(sbs), .sweep_rate(16'h0400), .marker_pos(mk),
        .trig_src_ext(ext), .trig_polarity(pol), .trig_period(tp),
        .ext_trig_pin(pin), .manual_trigger_key(man), .remote_trigger(rem), .start_cmd(sta),
        .stop_cmd(stp), .hold_cmd(hld), .resume_cmd(res), .force_start_value(fst),
        .force_stop_value(fsp), .idle_output_level(idl), .idle_percent(7'h2A),
        .phase_setting(16'h1111), .start_phase(16'h2222), .stop_phase(16'h3333),
        .stop_granularity(gran), .wave_cycle_mark(cmk), .wave_half_mark(hmk),
        .wave_ref_phase(cmk), .sync_output_select(ssel), .osc_enable(osc), .sweep_pos(pos),
        .sel_start_value(s0), .sel_stop_value(s1), .idle_use_percent(iup),
        .idle_level_pct(ipl), .osc_start_phase(osp), .osc_stop_phase(opp),
        .trig_lamp(lamp), .conflict(cfl), .sync_out(so), .xdrive_level(xd));
    // Free-running 40 MHz clock
    initial forever #12.5 mclk = ~mclk;
    // Count every comparison, report each mismatch at once
    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask
    // One-cycle command pulse driven at the falling edge; kind 5 instead selects the internal source
    task automatic pulse(input int k);
        @(negedge mclk);
        case (k)
            1: man = 1'b1;
            2: rem = 1'b1;
            3: sta = 1'b1;
            4: fire = 1'b1;
            5: ext = 1'b0;
            6: stp = 1'b1;
            7: hld = 1'b1;
            8: res = 1'b1;
            9: fst = 1'b1;
            default: fsp = 1'b1;
        endcase
        @(negedge mclk);
        {man, rem, sta, fire, stp, hld, res, fst, fsp} = '0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // Count the samples in which the sync terminal is low
    task automatic count_low(input int len);
        n = 0;
        repeat (len) begin
            @(negedge mclk);
            if (so === 1'b0) n++;
        end
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #(25 * 20000);
        error_cnt++;
        print_verdict();
    end
    initial begin
        wt(16);
        chk(s0 === 1'b1 && pos === 15'h0 && so === 1'b1 && lamp === 1'b0, "reset");
        resetn = 1'b1;
        // Trigger sources, polarity and validity; external with polarity off for manual use
        foreach (rows[i]) begin
            sty = swq_style_t'(rows[i][5:4]);
            valid = rows[i][3];
            pol = swq_pol_t'(rows[i][2:1]);
            pulse(int'(rows[i][8:6]));
            wt(12);
            chk((pos != 15'h0) === rows[i][0], "trigger acceptance");
            chk(cfl === ~rows[i][3], "conflict flag");
            if (i == 0) chk(lamp === 1'b1, "lamp");
            ext = 1'b1;
            pol = SWQ_POL_OFF;
            valid = 1'b1;
            pulse(6);
            wt(2);
            chk(pos === 15'h0 && s0 === 1'b1 && s1 === 1'b0, "stop value");
        end
        // Sweep sync falls at start; hold, resume and trigger during hold
        ssel = `SWQ_SYNC_SWEEP;
        pulse(1);
        flag = 1'b0;
        repeat (4) begin
            @(negedge mclk);
            if (so === 1'b0) flag = 1'b1;
        end
        chk(flag, "sweep sync");
        pulse(7);
        wt(1);
        p = pos;
        wt(3);
        chk(pos === p && p != 15'h0, "hold");
        pulse(8);
        wt(2);
        chk(pos > p, "resume");
        pulse(7);
        p = pos;
        pulse(1);
        chk(pos < p, "trigger in hold");
        // Completion: one-way returns to start, shuttle waits at stop
        wt(40);
        chk(s0 === 1'b1 && pos === 15'h0, "one-way end");
        shut = 1'b1;
        pulse(2);
        wt(80);
        chk(s1 === 1'b1, "shuttle end");
        // Forced values keep a gated synthesizer oscillating until stop
        sty = SWQ_GATED;
        phs = 1'b1;
        pulse(6);
        wt(2);
        chk(osc === 1'b0, "gate closed");
        pulse(10);
        wt(1);
        chk(s1 === 1'b1 && osc === 1'b1, "force stop");
        pulse(9);
        wt(1);
        chk(s0 === 1'b1 && osc === 1'b1, "force start");
        chk(osp === 16'h2222 && opp === 16'h3333, "phase bounds");
        chk(iup === idl && ipl === 7'h2A, "idle level");
        // Half-cycle granularity lets the gate close within half a waveform cycle
        gran = 1'b1;
        pulse(6);
        wt(5);
        chk(osc === 1'b0, "force ended");
        sty = SWQ_CONT;
        wt(6);
        chk(pos != 15'h0, "continuous");
        // Marker sync low for marker over rate clocks, clamped near the start
        pulse(6);
        sty = SWQ_SINGLE;
        shut = 1'b0;
        ssel = `SWQ_SYNC_MARK;
        mk = 15'h2000;
        pulse(1);
        count_low(20);
        chk(n == 8, "marker low time");
        mk = 15'h0000;
        pulse(1);
        count_low(20);
        chk(n == 1, "marker clamp");
        // X drive follows elapsed time; a falling sweep runs it downwards
        ssel = `SWQ_SYNC_XDRIVE;
        pulse(1);
        wt(4);
        chk(xd === 15'h1000 && so === 1'b0, "x drive rising");
        sbs = 1'b1;
        wt(1);
        chk(xd === `SWQ_POS_MAX - 15'h1400, "x drive falling");
        // Reference sync: one high clock per waveform cycle
        ssel = `SWQ_SYNC_REF;
        wt(1);
        count_low(16);
        chk(n == 14, "reference sync");
        // Internal trigger restarts the sweep once per programmed period
        pulse(6);
        tp = 32'h0000_0010;
        ext = 1'b0;
        p = 15'h0;
        repeat (48) begin
            @(negedge mclk);
            if (pos > p) p = pos;
        end
        chk(p === 15'h3C00, "trigger period");
        print_verdict();
    end
endmodule
`default_nettype wire
